// file: design/kbc_consts.vh
// Constants for the keyboard controller host mailbox port.
// Assumes inclusion by bare name from the design files only.
`ifndef KBC_CONSTS_VH
`define KBC_CONSTS_VH

// Host I/O addresses, qualified by the address enable
`define KBC_ADDR_DATA 8'h60
`define KBC_ADDR_CMD 8'h64
`define KBC_ADDR_CMOS_INDEX 8'h70
`define KBC_ADDR_CMOS_DATA 8'h71

// Host status port fields
`define KBC_ST_OBF 0
`define KBC_ST_IBF 1
`define KBC_ST_CD 3
`define KBC_STATUS_RESET 8'h00

// Controller port 2 fields
`define KBC_P2_A20 1
`define KBC_P2_MS_DATA 2
`define KBC_P2_MS_CLOCK 3
`define KBC_P2_KB_IRQ 4
`define KBC_P2_MS_IRQ 5
`define KBC_P2_KB_CLOCK 6
`define KBC_P2_KB_DATA 7
`define KBC_PORT2_RESET 8'h00
`define KBC_CMOS_INDEX_RESET 8'h00

// Powerdown states
`define KBC_PD_RUN 2'h0
`define KBC_PD_SOFT 2'h1
`define KBC_PD_HARD 2'h2

// Reset hold after release, for oscillator start-up
`define KBC_CLK_MHZ 25
`define KBC_RST_MIN_NS 1500

// Memory and buffer sizes
`define KBC_PROG_AW 11
`define KBC_RAM_AW 8
`define KBC_CMOS_AW 8
`define KBC_FIFO_DEPTH 8
`define KBC_FIFO_AW 3

`endif

// file: design/kbc_mem.v
// Flip-flop storage with one write port and a combinational read port.
// Assumes the user registers the read data where timing matters.
`timescale 1ns/10ps
`default_nettype none

module kbc_mem #(
	parameter W = 8,
	parameter AW = 8
) (
	input wire clk,
	input wire wr,
	input wire [AW-1:0] waddr,
	input wire [W-1:0] wdata,
	input wire [AW-1:0] raddr,
	output wire [W-1:0] rdata
);
	reg [W-1:0] mem [0:(1<<AW)-1];

	// No reset: contents are undefined until written
	always @(posedge clk) begin
		if (wr) begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata = mem[raddr];
endmodule

`default_nettype wire

// file: design/kbc_fifo.v
// Synchronous FIFO of flip-flops, valid and ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module kbc_fifo #(
	parameter W = 9,
	parameter D = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire srst,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	localparam [AW:0] FULL = D[AW:0];
	localparam LAST_WIDE = D - 1;
	localparam [AW-1:0] LAST = LAST_WIDE[AW-1:0];
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0] count;
	wire push;
	wire pop;

	assign in_ready = (count != FULL);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge clk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp <= (wp == LAST) ? {AW{1'b0}} : wp + 1'b1;
			end
			if (pop) begin
				rp <= (rp == LAST) ? {AW{1'b0}} : rp + 1'b1;
			end
			if (push & ~pop) begin
				count <= count + 1'b1;
			end else if (pop & ~push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// file: design/kbc_host_mailbox_port.v
// Host mailbox port of the embedded keyboard controller.
// Assumes host strobes and pin levels synchronous to clk; the
// instruction core sits outside and talks through the ctl_ ports.
//
// Overview of operation
// - Host data write stores byte, tag 0, full
// - Host command write stores byte, tag 1, full
// - Host data read clears output full flag; aux flag only in flag mode
// - CMOS index selects location for data port
// - Controller mailbox write sets output full flag
// - Status bit 3 records address bit 2
// - Flag mode keyboard irq gates output full flag
// - Otherwise keyboard irq follows port bit 4
// - Reset drives keyboard irq low
// - Flag mode mouse irq is inverted input full
// - Otherwise mouse irq follows port bit 5
// - Port bit 1 routed to general pin 25
// - Four open-drain pins driven inverted from port
// - Pin levels fed back to sense inputs
// - Halt stops ALU clock, timer keeps running
// - Host data or command write wakes; call or next instruction
// - Reset exit restarts fetch at address zero
// - Stop halts oscillator; reset hold for start-up follows srst only, not wake
// - Two interrupt sources: input full, timer overflow
// - Program memory 2K, data memory 256 bytes
// - Controller mailbox read pops byte; full clears when buffer empties
// - Status clears on reset; host read only
`timescale 1ns/10ps
`default_nettype none
`include "kbc_consts.vh"

module kbc_host_mailbox_port (
	input wire clk,
	input wire srst,
	input wire host_aen_n,
	input wire [7:0] host_addr,
	input wire host_rd_n,
	input wire host_wr_n,
	input wire [7:0] host_data_in,
	output reg [7:0] host_data_out,
	output reg host_data_oe_n,
	output reg host_wr_ready,
	output reg keyboard_irq_out,
	output reg mouse_irq_out,
	output reg general_pin_25,
	input wire keyboard_clock_pin_in,
	output wire keyboard_clock_pin_out,
	output wire keyboard_clock_pin_oe_n,
	input wire keyboard_data_pin_in,
	output wire keyboard_data_pin_out,
	output wire keyboard_data_pin_oe_n,
	input wire mouse_clock_pin_in,
	output wire mouse_clock_pin_out,
	output wire mouse_clock_pin_oe_n,
	input wire mouse_data_pin_in,
	output wire mouse_data_pin_out,
	output wire mouse_data_pin_oe_n,
	output wire kb_clock_sense_input,
	output wire kb_data_sense_bit,
	output wire ms_clock_sense_input,
	output wire ms_data_sense_bit,
	input wire ctl_mbox_wr,
	input wire [7:0] ctl_mbox_wdata,
	input wire ctl_mbox_rd,
	output reg [7:0] ctl_mbox_rdata,
	output reg [7:0] ctl_status,
	input wire ctl_status_wr,
	input wire [7:0] ctl_status_wdata,
	input wire ctl_port2_wr,
	input wire [7:0] ctl_port2_wdata,
	output reg [7:0] ctl_port2,
	input wire ctl_en_flags,
	output reg flag_mode,
	input wire ctl_aux_clear,
	output reg aux_output_full,
	input wire ctl_halt,
	input wire ctl_stop,
	output reg alu_clock_run,
	output reg osc_run,
	output reg wake_call_irq,
	output reg wake_next_insn,
	output reg cpu_reset_out,
	input wire ctl_ibf_irq_en,
	input wire ctl_timer_irq_en,
	input wire timer_overflow,
	input wire ctl_timer_ack,
	output reg ctl_irq_ibf,
	output reg ctl_irq_timer,
	input wire ctl_prog_wr,
	input wire [10:0] ctl_prog_addr,
	input wire [7:0] ctl_prog_wdata,
	input wire [10:0] ctl_fetch_addr,
	output reg [7:0] ctl_fetch_data,
	input wire ctl_ram_wr,
	input wire [7:0] ctl_ram_addr,
	input wire [7:0] ctl_ram_wdata,
	output reg [7:0] ctl_ram_rdata
);
	localparam RST_HOLD_WIDE =
		(`KBC_RST_MIN_NS * `KBC_CLK_MHZ + 999) / 1000;
	localparam [5:0] RST_HOLD = RST_HOLD_WIDE[5:0];

	reg rd_n_q;
	reg wr_n_q;
	reg [7:0] out_data;
	reg output_full_flag;
	reg last_cd;
	reg [7:0] user_bits;
	reg [7:0] cmos_index;
	reg [1:0] pd_state;
	reg [5:0] rst_cnt;
	reg timer_pend;
	reg [3:0] pin_oe_n;
	reg [3:0] pin_sense;
	wire sel;
	wire rd_pulse;
	wire wr_pulse;
	wire hit_data;
	wire hit_cmd;
	wire hit_idx;
	wire hit_cmos;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [8:0] fifo_out_data;
	wire push;
	wire pop;
	wire input_full_flag;
	wire cd_bit;
	wire [7:0] status_word;
	wire [7:0] cmos_rdata;
	wire [7:0] prog_rdata;
	wire [7:0] ram_rdata;
	wire [3:0] drive_bits;
	wire [3:0] pin_in;

	// Strobes act once, on their falling edge
	assign sel = ~host_aen_n;
	assign rd_pulse = sel & ~host_rd_n & rd_n_q;
	assign wr_pulse = sel & ~host_wr_n & wr_n_q;
	assign hit_data = (host_addr == `KBC_ADDR_DATA);
	assign hit_cmd = (host_addr == `KBC_ADDR_CMD);
	assign hit_idx = (host_addr == `KBC_ADDR_CMOS_INDEX);
	assign hit_cmos = (host_addr == `KBC_ADDR_CMOS_DATA);

	// Writes into a full buffer are dropped; host_wr_ready shows full one cycle late
	assign push = wr_pulse & (hit_data | hit_cmd) & fifo_in_ready;
	assign pop = ctl_mbox_rd & fifo_out_valid;
	assign input_full_flag = fifo_out_valid;
	assign cd_bit = fifo_out_valid ? fifo_out_data[8] : last_cd;

	assign status_word = {user_bits[7:4], cd_bit, user_bits[2], input_full_flag, output_full_flag};

	kbc_fifo #(
		.W(9),
		.D(`KBC_FIFO_DEPTH),
		.AW(`KBC_FIFO_AW)
	) u_in_fifo (
		.clk(clk),
		.srst(srst),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({host_addr[2], host_data_in}),
		.out_valid(fifo_out_valid),
		.out_ready(ctl_mbox_rd),
		.out_data(fifo_out_data)
	);

	kbc_mem #(
		.W(8),
		.AW(`KBC_CMOS_AW)
	) u_cmos (
		.clk(clk),
		.wr(wr_pulse & hit_cmos),
		.waddr(cmos_index),
		.wdata(host_data_in),
		.raddr(cmos_index),
		.rdata(cmos_rdata)
	);

	kbc_mem #(
		.W(8),
		.AW(`KBC_PROG_AW)
	) u_prog (
		.clk(clk),
		.wr(ctl_prog_wr),
		.waddr(ctl_prog_addr),
		.wdata(ctl_prog_wdata),
		.raddr(ctl_fetch_addr),
		.rdata(prog_rdata)
	);

	kbc_mem #(
		.W(8),
		.AW(`KBC_RAM_AW)
	) u_ram (
		.clk(clk),
		.wr(ctl_ram_wr),
		.waddr(ctl_ram_addr),
		.wdata(ctl_ram_wdata),
		.raddr(ctl_ram_addr),
		.rdata(ram_rdata)
	);

	// Host side registers and read path
	always @(posedge clk) begin
		if (srst) begin
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			host_data_out <= 8'h00;
			host_data_oe_n <= 1'b1;
			host_wr_ready <= 1'b0;
			cmos_index <= `KBC_CMOS_INDEX_RESET;
			last_cd <= 1'b0;
		end else begin
			rd_n_q <= host_rd_n | host_aen_n;
			wr_n_q <= host_wr_n | host_aen_n;
			host_wr_ready <= fifo_in_ready;
			host_data_oe_n <= ~(sel & ~host_rd_n &
				(hit_data | hit_cmd | hit_idx | hit_cmos));
			if (wr_pulse & hit_idx) begin
				cmos_index <= host_data_in;
			end
			if (push) begin
				last_cd <= host_addr[2];
			end
			if (rd_pulse) begin
				if (hit_data) begin
					host_data_out <= out_data;
				end else if (hit_cmd) begin
					host_data_out <= status_word;
				end else if (hit_idx) begin
					host_data_out <= cmos_index;
				end else if (hit_cmos) begin
					host_data_out <= cmos_rdata;
				end
			end
		end
	end

	// Output mailbox and flags; a set wins over a clear
	always @(posedge clk) begin
		if (srst) begin
			out_data <= 8'h00;
			output_full_flag <= 1'b0;
			aux_output_full <= 1'b0;
			user_bits <= `KBC_STATUS_RESET;
			flag_mode <= 1'b0;
		end else begin
			if (ctl_mbox_wr) begin
				out_data <= ctl_mbox_wdata;
				output_full_flag <= 1'b1;
			end else if (rd_pulse & hit_data) begin
				output_full_flag <= 1'b0;
			end
			if (ctl_mbox_wr) begin
				aux_output_full <= 1'b1;
			end else if (flag_mode & rd_pulse & hit_data) begin
				aux_output_full <= 1'b0;
			end else if (ctl_aux_clear) begin
				aux_output_full <= 1'b0;
			end
			if (ctl_status_wr) begin
				user_bits <= ctl_status_wdata;
			end
			if (ctl_en_flags) begin
				flag_mode <= 1'b1;
			end
		end
	end

	// Controller side views; ctl_status lags by one cycle
	always @(posedge clk) begin
		if (srst) begin
			ctl_mbox_rdata <= 8'h00;
			ctl_status <= `KBC_STATUS_RESET;
			ctl_port2 <= `KBC_PORT2_RESET;
			ctl_fetch_data <= 8'h00;
			ctl_ram_rdata <= 8'h00;
		end else begin
			if (pop) begin
				ctl_mbox_rdata <= fifo_out_data[7:0];
			end
			ctl_status <= status_word;
			if (ctl_port2_wr) begin
				ctl_port2 <= ctl_port2_wdata;
			end
			ctl_fetch_data <= prog_rdata;
			ctl_ram_rdata <= ram_rdata;
		end
	end

	// Host interrupt lines, one cycle behind the flags
	always @(posedge clk) begin
		if (srst) begin
			keyboard_irq_out <= 1'b0;
			mouse_irq_out <= 1'b0;
			general_pin_25 <= 1'b0;
		end else begin
			if (flag_mode) begin
				keyboard_irq_out <= ctl_port2[`KBC_P2_KB_IRQ] & output_full_flag;
				mouse_irq_out <= ctl_port2[`KBC_P2_MS_IRQ] & ~input_full_flag;
			end else begin
				keyboard_irq_out <= ctl_port2[`KBC_P2_KB_IRQ];
				mouse_irq_out <= ctl_port2[`KBC_P2_MS_IRQ];
			end
			general_pin_25 <= ctl_port2[`KBC_P2_A20];
		end
	end

	// Pin order: kb clock, kb data, mouse clock, mouse data
	assign drive_bits = {ctl_port2[`KBC_P2_MS_DATA],
		ctl_port2[`KBC_P2_MS_CLOCK], ctl_port2[`KBC_P2_KB_DATA],
		ctl_port2[`KBC_P2_KB_CLOCK]};
	assign pin_in = {mouse_data_pin_in, mouse_clock_pin_in,
		keyboard_data_pin_in, keyboard_clock_pin_in};

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_pin
			// Port bit high pulls the line low; released otherwise
			always @(posedge clk) begin
				if (srst) begin
					pin_oe_n[i] <= 1'b1;
					pin_sense[i] <= 1'b1;
				end else begin
					pin_oe_n[i] <= ~drive_bits[i];
					pin_sense[i] <= pin_in[i];
				end
			end
		end
	endgenerate

	// Open drain: only ever drives zero
	assign keyboard_clock_pin_out = 1'b0;
	assign keyboard_data_pin_out = 1'b0;
	assign mouse_clock_pin_out = 1'b0;
	assign mouse_data_pin_out = 1'b0;
	assign keyboard_clock_pin_oe_n = pin_oe_n[0];
	assign keyboard_data_pin_oe_n = pin_oe_n[1];
	assign mouse_clock_pin_oe_n = pin_oe_n[2];
	assign mouse_data_pin_oe_n = pin_oe_n[3];
	assign kb_clock_sense_input = pin_sense[0];
	assign kb_data_sense_bit = pin_sense[1];
	assign ms_clock_sense_input = pin_sense[2];
	assign ms_data_sense_bit = pin_sense[3];

	// Powerdown control and restart
	always @(posedge clk) begin
		if (srst) begin
			pd_state <= `KBC_PD_RUN;
			alu_clock_run <= 1'b1;
			osc_run <= 1'b1;
			wake_call_irq <= 1'b0;
			wake_next_insn <= 1'b0;
			cpu_reset_out <= 1'b1;
			rst_cnt <= RST_HOLD;
		end else begin
			wake_call_irq <= 1'b0;
			wake_next_insn <= 1'b0;
			// Core stays in reset long enough for the oscillator
			if (rst_cnt != 6'h00) begin
				rst_cnt <= rst_cnt - 1'b1;
			end
			cpu_reset_out <= (rst_cnt > 6'h01);
			case (pd_state)
			`KBC_PD_RUN: begin
				if (ctl_stop) begin
					pd_state <= `KBC_PD_HARD;
					alu_clock_run <= 1'b0;
					osc_run <= 1'b0;
				end else if (ctl_halt) begin
					pd_state <= `KBC_PD_SOFT;
					alu_clock_run <= 1'b0;
				end
			end
			`KBC_PD_SOFT, `KBC_PD_HARD: begin
				if (push) begin
					pd_state <= `KBC_PD_RUN;
					alu_clock_run <= 1'b1;
					osc_run <= 1'b1;
					wake_call_irq <= ctl_ibf_irq_en;
					wake_next_insn <= ~ctl_ibf_irq_en;
				end
			end
			default: begin
				pd_state <= `KBC_PD_RUN;
				alu_clock_run <= 1'b1;
				osc_run <= 1'b1;
			end
			endcase
		end
	end

	// Interrupt requests to the core; timer keeps running in halt
	always @(posedge clk) begin
		if (srst) begin
			timer_pend <= 1'b0;
			ctl_irq_ibf <= 1'b0;
			ctl_irq_timer <= 1'b0;
		end else begin
			if (timer_overflow) begin
				timer_pend <= 1'b1;
			end else if (ctl_timer_ack) begin
				timer_pend <= 1'b0;
			end
			ctl_irq_ibf <= input_full_flag & ctl_ibf_irq_en;
			ctl_irq_timer <= timer_pend & ctl_timer_irq_en;
		end
	end
endmodule

`default_nettype wire

// file: tb/kbc_props.sv
// Checker for the keyboard controller host mailbox port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module kbc_props (
	input wire logic clk,
	input wire logic srst,
	input wire logic keyboard_irq_out,
	input wire logic mouse_irq_out,
	input wire logic keyboard_clock_pin_oe_n,
	input wire logic keyboard_data_pin_oe_n,
	input wire logic mouse_clock_pin_oe_n,
	input wire logic mouse_data_pin_oe_n,
	input wire logic [7:0] ctl_status,
	input wire logic [7:0] ctl_port2,
	input wire logic ctl_mbox_wr,
	input wire logic flag_mode,
	input wire logic ctl_halt,
	input wire logic ctl_stop,
	input wire logic alu_clock_run,
	input wire logic osc_run,
	input wire logic host_aen_n,
	input wire logic host_rd_n,
	input wire logic [7:0] host_addr,
	input wire logic host_data_oe_n,
	input wire logic ctl_ibf_irq_en,
	input wire logic ctl_irq_ibf,
	input wire logic timer_overflow,
	input wire logic ctl_timer_irq_en,
	input wire logic ctl_irq_timer
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);

	keyboard_irq_out_reset_low_a: assert property ($fell(srst) |->
		!keyboard_irq_out && !mouse_irq_out) else $error("irq high after reset");
	pin_drive_a: assert property (!$past(srst) |-> {keyboard_clock_pin_oe_n,
		keyboard_data_pin_oe_n, mouse_clock_pin_oe_n, mouse_data_pin_oe_n} ==
		~$past({ctl_port2[6], ctl_port2[7], ctl_port2[3], ctl_port2[2]}))
		else $error("pin enable differs from port bits");
	obf_set_a: assert property (ctl_mbox_wr |=> ##1 ctl_status[0])
		else $error("output full not set by mailbox write");
	keyboard_irq_out_follow_a: assert property ((!flag_mode && $stable(ctl_port2))[*3]
		|-> keyboard_irq_out == ctl_port2[4]) else $error("keyboard_irq_out not port bit");
	keyboard_irq_out_gate_a: assert property ((flag_mode && $stable(ctl_port2))[*3]
		|-> keyboard_irq_out == (ctl_port2[4] && ctl_status[0]))
		else $error("keyboard_irq_out not gated output full");
	mouse_irq_out_follow_a: assert property ((!flag_mode && $stable(ctl_port2))[*3]
		|-> mouse_irq_out == ctl_port2[5]) else $error("mouse_irq_out not port bit");
	mouse_irq_out_gate_a: assert property ((flag_mode && $stable(ctl_port2))[*3]
		|-> mouse_irq_out == (ctl_port2[5] && !ctl_status[1]))
		else $error("mouse_irq_out not inverted input full");
	flags_sticky_a: assert property (flag_mode |=> flag_mode)
		else $error("flag mode dropped");
	halt_alu_a: assert property (ctl_halt && !ctl_stop && alu_clock_run
		|=> !alu_clock_run && osc_run) else $error("halt did not stop alu");
	stop_osc_a: assert property (ctl_stop && alu_clock_run
		|=> !alu_clock_run && !osc_run) else $error("stop did not halt osc");
	read_oe_a: assert property (host_data_oe_n == !$past(!host_aen_n
		&& !host_rd_n && (host_addr == 8'h60 || host_addr == 8'h64
		|| host_addr == 8'h70 || host_addr == 8'h71)))
		else $error("data enable differs from decoded read");
	ibf_irq_a: assert property (ctl_irq_ibf ==
		(ctl_status[1] && $past(ctl_ibf_irq_en)))
		else $error("input full request wrong");
	timer_irq_a: assert property (timer_overflow ##1 ctl_timer_irq_en
		|=> ctl_irq_timer) else $error("timer overflow request missing");
endmodule
bind kbc_host_mailbox_port kbc_props i_kbc_props (.*);
`default_nettype wire

// file: tb/kbc_host_model.sv
// Host processor model issuing strobed I/O cycles.
// Assumes the caller waits for each task to return.
`timescale 1ns/10ps
`default_nettype none
module kbc_host_model (
	input wire logic clk,
	output logic host_aen_n,
	output logic [7:0] host_addr,
	output logic host_rd_n,
	output logic host_wr_n,
	output logic [7:0] host_data_in,
	input wire logic [7:0] host_data_out
);
	initial begin
		{host_aen_n, host_rd_n, host_wr_n} = 3'h7;
		host_addr = 8'h00;
		host_data_in = 8'h00;
	end
	// Strobe held two edges, then high one cycle before the next
	task xfer(input logic rd, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		host_aen_n <= 1'h0;
		host_addr <= a;
		{host_rd_n, host_wr_n} <= {!rd, rd};
		host_data_in <= d;
		repeat (2) @(posedge clk);
		q = host_data_out;
		{host_aen_n, host_rd_n, host_wr_n} <= 3'h7;
		// Released bus shows no stale byte
		host_data_in <= ~d;
	endtask
endmodule
`default_nettype wire

// file: tb/kbc_host_mailbox_port_test.sv
// Self-checking bench for the keyboard controller host mailbox port.
// Assumes pull-ups on the four serial pins.
`timescale 1ns/10ps
`default_nettype none
module kbc_host_mailbox_port_test;
	logic clk = 1'h0;
	logic srst = 1'h1;
	logic ctl_mbox_wr = 1'h0, ctl_mbox_rd = 1'h0, ctl_port2_wr = 1'h0;
	logic ctl_en_flags = 1'h0, ctl_halt = 1'h0, ctl_ibf_irq_en = 1'h0;
	logic ctl_status_wr = 1'h0, ctl_aux_clear = 1'h0, ctl_stop = 1'h0;
	logic [7:0] ctl_mbox_wdata = 8'h00, ctl_port2_wdata = 8'h00;
	logic [7:0] ctl_status_wdata = 8'h00;
	logic ctl_prog_wr, ctl_ram_wr, ctl_timer_irq_en, timer_overflow;
	logic ctl_timer_ack, host_aen_n, host_rd_n, host_wr_n;
	logic [10:0] ctl_prog_addr, ctl_fetch_addr;
	logic [7:0] ctl_prog_wdata, ctl_ram_addr, ctl_ram_wdata;
	logic host_data_oe_n, host_wr_ready, general_pin_25;
	logic [7:0] host_addr, host_data_in, host_data_out;
	logic keyboard_irq_out, mouse_irq_out, flag_mode, aux_output_full;
	logic keyboard_clock_pin_in, keyboard_data_pin_in;
	logic mouse_clock_pin_in, mouse_data_pin_in;
	logic keyboard_clock_pin_out, keyboard_data_pin_out;
	logic mouse_clock_pin_out, mouse_data_pin_out;
	logic keyboard_clock_pin_oe_n, keyboard_data_pin_oe_n;
	logic mouse_clock_pin_oe_n, mouse_data_pin_oe_n;
	logic kb_clock_sense_input, kb_data_sense_bit;
	logic ms_clock_sense_input, ms_data_sense_bit;
	logic [7:0] ctl_mbox_rdata, ctl_status, ctl_port2;
	logic [7:0] ctl_fetch_data, ctl_ram_rdata;
	logic alu_clock_run, osc_run, wake_call_irq, wake_next_insn;
	logic cpu_reset_out, ctl_irq_ibf, ctl_irq_timer;
	integer seed = 32'h4844;
	integer n_errors = 0, n_compared = 0, cyc = 0, n_wake = 0, i;
	integer n_next = 0;
	logic [63:0] r, rb;
	logic [7:0] q, dat [0:8], idx [0:1];
	logic tg [0:8];

	// Pull-ups lift a released pin
	assign keyboard_clock_pin_in =
		keyboard_clock_pin_oe_n | keyboard_clock_pin_out;
	assign keyboard_data_pin_in =
		keyboard_data_pin_oe_n | keyboard_data_pin_out;
	assign mouse_clock_pin_in = mouse_clock_pin_oe_n | mouse_clock_pin_out;
	assign mouse_data_pin_in = mouse_data_pin_oe_n | mouse_data_pin_out;

	kbc_host_mailbox_port i_kbc_host_mailbox_port (.*);
	kbc_host_model i_kbc_host_model (.*);

	always #20 clk = ~clk;

	// Timer and memory ports kept busy with random traffic
	initial forever begin
		rb = {$random(seed), $random(seed)};
		{ctl_prog_wr, ctl_prog_addr, ctl_prog_wdata, ctl_fetch_addr, ctl_ram_wr,
			ctl_ram_addr, ctl_ram_wdata, ctl_timer_irq_en, timer_overflow,
			ctl_timer_ack} <= rb[50:0];
		@(posedge clk);
	end

	function automatic logic [7:0] st_exp(input logic output_full_flag, input_full_flag, cd);
		st_exp = {4'h0, cd, 1'h0, input_full_flag, output_full_flag};
	endfunction

	task final_report;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input string nm, input logic [7:0] g, input logic [7:0] e);
		n_compared = n_compared + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	task hw(input logic [7:0] a, input logic [7:0] d);
		i_kbc_host_model.xfer(1'h0, a, d, q);
	endtask

	task hr(input logic [7:0] a);
		i_kbc_host_model.xfer(1'h1, a, 8'h00, q);
	endtask

	// One-cycle controller pulse, then let status and irqs settle
	task strobe(input logic [4:0] s, input logic [7:0] d);
		@(posedge clk);
		{ctl_halt, ctl_en_flags, ctl_port2_wr, ctl_mbox_wr, ctl_mbox_rd} <= s;
		ctl_mbox_wdata <= d;
		ctl_port2_wdata <= d;
		@(posedge clk);
		{ctl_halt, ctl_en_flags, ctl_port2_wr, ctl_mbox_wr, ctl_mbox_rd} <= 5'h00;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wake_call_irq === 1'h1)
			n_wake <= n_wake + 1;
		if (wake_next_insn === 1'h1)
			n_next <= n_next + 1;
		if (cyc == 4000) begin
			n_errors = n_errors + 1;
			final_report;
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'h0;
		@(negedge clk);
		chk("core_reset", cpu_reset_out, 8'h01);
		hr(8'h64);
		chk("status", q, 8'h00);
		for (i = 0; i < 9; i = i + 1) begin
			r = {$random(seed), $random(seed)};
			dat[i] = r[7:0];
			tg[i] = r[8];
			hw(tg[i] ? 8'h64 : 8'h60, dat[i]);
		end
		chk("wr_ready", host_wr_ready, 8'h00);
		hr(8'h64);
		chk("status", q, st_exp(1'h0, 1'h1, tg[0]));
		for (i = 0; i < 8; i = i + 1) begin
			chk("tag", ctl_status[3], tg[i]);
			strobe(5'h01, 8'h00);
			chk("mbox", ctl_mbox_rdata, dat[i]);
		end
		// Unmapped address must not fill the input side
		hw(8'h61, 8'h3C);
		repeat (2) @(negedge clk);
		chk("ibf", ctl_status[1], 8'h00);
		chk("core_reset", cpu_reset_out, 8'h00);
		strobe(5'h04, 8'h10);
		chk("keyboard_irq_out", keyboard_irq_out, 8'h01);
		for (i = 0; i < 4; i = i + 1) begin
			r = {$random(seed), $random(seed)};
			strobe(5'h04, r[7:0]);
			chk("sense", {4'h0, kb_clock_sense_input, kb_data_sense_bit,
				ms_clock_sense_input, ms_data_sense_bit},
				{4'h0, ~r[6], ~r[7], ~r[3], ~r[2]});
			chk("a20", general_pin_25, r[1]);
		end
		strobe(5'h08, 8'h00);
		strobe(5'h04, 8'h30);
		r = {$random(seed), $random(seed)};
		strobe(5'h02, r[7:0]);
		chk("keyboard_irq_out", keyboard_irq_out, 8'h01);
		chk("aux", aux_output_full, 8'h01);
		hr(8'h64);
		chk("obf", q[1:0], 8'h01);
		hr(8'h60);
		chk("out_data", q, r[7:0]);
		repeat (2) @(negedge clk);
		chk("keyboard_irq_out", keyboard_irq_out, 8'h00);
		chk("aux", aux_output_full, 8'h00);
		chk("mouse_irq_out", mouse_irq_out, 8'h01);
		hw(8'h60, 8'h5A);
		repeat (2) @(negedge clk);
		chk("mouse_irq_out", mouse_irq_out, 8'h00);
		ctl_ibf_irq_en <= 1'h1;
		strobe(5'h10, 8'h00);
		chk("alu_run", alu_clock_run, 8'h00);
		hw(8'h60, 8'hA5);
		repeat (2) @(negedge clk);
		chk("wake", n_wake[7:0], 8'h01);
		chk("alu_run", alu_clock_run, 8'h01);
		// Hard powerdown, woken with the input interrupt off
		ctl_ibf_irq_en <= 1'h0;
		@(posedge clk) ctl_stop <= 1'h1;
		@(posedge clk) ctl_stop <= 1'h0;
		repeat (2) @(negedge clk);
		chk("osc_run", osc_run, 8'h00);
		hw(8'h60, 8'h00);
		repeat (2) @(negedge clk);
		chk("osc_run", osc_run, 8'h01);
		chk("wake_next", n_next[7:0], 8'h01);
		chk("wake", n_wake[7:0], 8'h01);
		r = {$random(seed), $random(seed)};
		idx[0] = r[7:0];
		idx[1] = ~r[7:0];
		for (i = 0; i < 2; i = i + 1) begin
			hw(8'h70, idx[i]);
			hw(8'h71, r[15:8] ^ i[7:0]);
		end
		for (i = 0; i < 2; i = i + 1) begin
			hw(8'h70, idx[i]);
			hr(8'h71);
			chk("cmos", q, r[15:8] ^ i[7:0]);
		end
		final_report;
	end
endmodule
`default_nettype wire
